// [include/serial_port_pkg.sv]
package serial_port_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_BUFFER = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_POWER = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // control/status bit positions
    localparam int CTRL_RX_DONE = 0;
    localparam int CTRL_TX_DONE = 1;
    localparam int CTRL_RX_NINTH = 2;
    localparam int CTRL_TX_NINTH = 3;
    localparam int CTRL_RX_ENABLE = 4;
    localparam int CTRL_MP_ENABLE = 5;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_MODE_HI = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // power control: baud doubler position and reset value
    localparam int PWR_DOUBLER = 7;
    localparam logic PWR_DOUBLER_RESET = 1'b0;

    // status: busy indications
    localparam int STAT_TX_BUSY = 0;
    localparam int STAT_RX_BUSY = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // modes and timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHIFT,
        MODE_UART8,
        MODE_UART9_FIXED,
        MODE_UART9_VAR
    } mode_t;

    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS_8 = 10;
    localparam int FRAME_BITS_9 = 11;
    localparam int SHIFT_DIV = 12;
    localparam int SHIFT_HALF = SHIFT_DIV / 2;
    localparam int OVERSAMPLE = 16;
    localparam int SAMPLE_POINT = OVERSAMPLE / 2;
    localparam int FIXED_RATE_DIV = 64;
    localparam int TIMER_RATE_DIV = 32;
    localparam int FIXED_TICK_DIV = FIXED_RATE_DIV / OVERSAMPLE;
    localparam int TIMER_TICK_DIV = TIMER_RATE_DIV / OVERSAMPLE;
    // receive samples after the start bit: mode 1 data+stop, modes 2/3 data+ninth+stop
    localparam int RX_SAMPLES_8 = DATA_BITS + 1;
    localparam int RX_SAMPLES_9 = DATA_BITS + 2;

endpackage

// [rtl/baud_tick_gen.sv]
`timescale 1ns/1ps
module baud_tick_gen (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // rate selection
    input wire serial_port_pkg::mode_t mode,
    input wire logic baudDoubler,
    input wire logic t1Overflow,
    // oversampling enable, sixteen per bit
    output logic tick16
);
    import serial_port_pkg::*;

    logic [1:0] divCnt_r;
    logic prescale_r;
    logic tick16_r;
    wire logic [1:0] fixedLast = baudDoubler ? 2'(FIXED_TICK_DIV / 2 - 1) : 2'(FIXED_TICK_DIV - 1);
    wire logic timerMode = (mode == MODE_UART8) || (mode == MODE_UART9_VAR);
    wire logic timerTick = t1Overflow && (baudDoubler || prescale_r);

    assign tick16 = tick16_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            divCnt_r <= '0;
            prescale_r <= 1'b0;
            tick16_r <= 1'b0;
        end else begin
            divCnt_r <= (divCnt_r == fixedLast) ? 2'h0 : divCnt_r + 2'h1;
            if (t1Overflow)
                prescale_r <= (prescale_r + 1'b1) == 1'(TIMER_TICK_DIV - 1) ? 1'b1 : ~prescale_r;
            if (mode == MODE_UART9_FIXED)
                tick16_r <= (divCnt_r == fixedLast);
            else if (timerMode)
                tick16_r <= timerTick;
            else
                tick16_r <= 1'b0;
        end
    end
endmodule

// [rtl/bit_shifter.sv]
`timescale 1ns/1ps
module bit_shifter #(
    parameter int W = 11
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    input wire logic shiftEn,
    input wire logic serialIn,
    // contents, bit 0 leaves first
    output logic [W-1:0] value
);
    logic [W-1:0] value_r;

    assign value = value_r;

    always_ff @(posedge clk) begin
        if (srst)
            value_r <= '1;
        else if (load)
            value_r <= loadValue;
        else if (shiftEn)
            value_r <= {serialIn, value_r[W-1:1]};
    end
endmodule

// [rtl/four_mode_serial_port.sv]
`timescale 1ns/1ps
// How it works
// - transmitter and receiver run at once, each on its own state machine
// - in modes 1-3 the receiver takes a new frame while the buffer is unread; one byte may drop
// - buffer write loads transmit shifter; buffer read returns separate receive register
// - mode 0: data on rx pin both ways, tx pin carries clock, 8 bits lsb first
// - mode 1 frame: start 0, eight data lsb first, stop 1
// - mode 1 receive puts the stop bit into received ninth bit
// - modes 2/3 frame: start, eight data, ninth from transmit ninth bit, stop
// - modes 2/3 receive put ninth bit into received ninth bit; stop ignored
// - mode 2 rate is clock/64, or clock/32 with baud doubler set
// - mode 3 equals mode 2 except its rate follows timer 1 overflow
// - modes 1/3 rate is overflow rate times two-to-doubler over 32
// - with timer auto-reload the overflow input sets the rate accordingly
// - any buffer write with byte lane 0 enabled starts a transmission in every mode
// - mode 0 receive starts when receive done is 0, receive enable is 1 and no transmission is loading or shifting
// - modes 1-3 receive starts on a start bit only while enabled
// - modes 2/3 with multiprocessor enable: store only when ninth bit is 1
// - address bytes carry ninth bit 1, data bytes ninth bit 0
// - multiprocessor enable ignored in mode 0; mode 1 needs a valid stop bit
// - control register holds mode, ninth bits and both done flags
// - receive enable set allows reception, cleared blocks it
module four_mode_serial_port (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // axi4-lite write address
    input wire logic [serial_port_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [serial_port_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial pins
    input wire logic rxdIn,
    output logic rxdOut,
    output logic rxdOe,
    output logic txd,
    // timer 1 overflow pulse
    input wire logic t1Overflow
);
    import serial_port_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT} rx_state_t;

    function automatic logic addrKnown(input logic [ADDR_W-1:0] a);
        return (a == OFS_BUFFER) || (a == OFS_CONTROL) || (a == OFS_POWER) || (a == OFS_STATUS);
    endfunction

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic awHeld_r, wHeld_r, wLane0_r;
    logic [ADDR_W-1:0] awAddrQ_r;
    logic [7:0] wDataQ_r;

    wire logic awTake = awvalid && awready_r;
    wire logic wTake = wvalid && wready_r;
    wire logic arTake = arvalid && arready_r;
    wire logic doWrite = awHeld_r && wHeld_r && !bvalid_r;
    wire logic wrLane = doWrite && wLane0_r;
    wire logic wrBuffer = wrLane && (awAddrQ_r == OFS_BUFFER);
    wire logic wrControl = wrLane && (awAddrQ_r == OFS_CONTROL);
    wire logic wrPower = wrLane && (awAddrQ_r == OFS_POWER);

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            wLane0_r <= 1'b0;
            awAddrQ_r <= '0;
            wDataQ_r <= '0;
        end else begin
            if (awTake) begin
                awHeld_r <= 1'b1;
                awAddrQ_r <= awaddr;
                awready_r <= 1'b0;
            end
            if (wTake) begin
                wHeld_r <= 1'b1;
                wDataQ_r <= wdata[7:0];
                wLane0_r <= wstrb[0];
                wready_r <= 1'b0;
            end
            if (doWrite) begin
                bvalid_r <= 1'b1;
                bresp_r <= addrKnown(awAddrQ_r) ? RESP_OKAY : RESP_SLVERR;
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
            end
            if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] rxBuf_r;
    logic baudDoubler_r;
    logic rxStore;
    logic rxNinth;
    logic [7:0] rxData;
    logic txDone;
    logic txBusy, rxBusy;

    wire mode_t mode = mode_t'(ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO]);
    wire logic rxEnable = ctrl_r[CTRL_RX_ENABLE];
    wire logic mpEnable = ctrl_r[CTRL_MP_ENABLE];
    wire logic rxDoneFlag = ctrl_r[CTRL_RX_DONE];
    wire logic [7:0] powerRead = {baudDoubler_r, 7'h00};
    wire logic [7:0] statusRead = {6'h00, rxBusy, txBusy};
    wire logic [7:0] readSel =
        (araddr == OFS_BUFFER) ? rxBuf_r :
        (araddr == OFS_CONTROL) ? ctrl_r :
        (araddr == OFS_POWER) ? powerRead :
        (araddr == OFS_STATUS) ? statusRead : 8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (arTake) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= addrKnown(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= {24'h0000_00, readSel};
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // hardware sets win over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= CTRL_RESET;
            baudDoubler_r <= PWR_DOUBLER_RESET;
            rxBuf_r <= '0;
        end else begin
            if (wrControl)
                ctrl_r <= wDataQ_r;
            if (wrPower)
                baudDoubler_r <= wDataQ_r[PWR_DOUBLER];
            if (rxStore) begin
                rxBuf_r <= rxData;
                if (mode != MODE_SHIFT)
                    ctrl_r[CTRL_RX_NINTH] <= rxNinth;
                ctrl_r[CTRL_RX_DONE] <= 1'b1;
            end
            if (txDone)
                ctrl_r[CTRL_TX_DONE] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // bit rate
    // ------------------------------------------------------------
    logic tick16;

    baud_tick_gen u_baud (
        .clk(clk),
        .srst(srst),
        .mode(mode),
        .baudDoubler(baudDoubler_r),
        .t1Overflow(t1Overflow),
        .tick16(tick16)
    );

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    tx_state_t txState_r;
    logic [3:0] txSub_r, txBit_r;
    logic [FRAME_BITS_9-1:0] txFrame;
    logic txLoad, txShiftEn;

    wire logic txNinth = (mode == MODE_UART8) ? 1'b1 : ctrl_r[CTRL_TX_NINTH];
    wire logic [FRAME_BITS_9-1:0] txLoadValue = (mode == MODE_SHIFT) ?
        {3'b111, wDataQ_r} : {1'b1, txNinth, wDataQ_r, 1'b0};
    wire logic [3:0] txLast = (mode == MODE_SHIFT) ? 4'(DATA_BITS - 1) :
        (mode == MODE_UART8) ? 4'(FRAME_BITS_8 - 1) : 4'(FRAME_BITS_9 - 1);
    wire logic txBitEnd = (txState_r == TX_SHIFT) ? (txSub_r == 4'(SHIFT_DIV - 1)) :
        (tick16 && (txSub_r == 4'(OVERSAMPLE - 1)));

    assign txLoad = wrBuffer;
    assign txShiftEn = (txState_r != TX_IDLE) && txBitEnd;
    assign txBusy = (txState_r != TX_IDLE);

    bit_shifter #(.W(FRAME_BITS_9)) u_txShift (
        .clk(clk),
        .srst(srst),
        .load(txLoad),
        .loadValue(txLoadValue),
        .shiftEn(txShiftEn),
        .serialIn(1'b1),
        .value(txFrame)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            txState_r <= TX_IDLE;
            txSub_r <= '0;
            txBit_r <= '0;
            txDone <= 1'b0;
        end else begin
            txDone <= 1'b0;
            if (txLoad) begin
                txState_r <= (mode == MODE_SHIFT) ? TX_SHIFT : TX_ASYNC;
                txSub_r <= '0;
                txBit_r <= '0;
            end else if (txState_r == TX_SHIFT || (txState_r == TX_ASYNC && tick16)) begin
                txSub_r <= txBitEnd ? 4'h0 : txSub_r + 4'h1;
                if (txBitEnd) begin
                    txBit_r <= txBit_r + 4'h1;
                    if (txBit_r == txLast) begin
                        txState_r <= TX_IDLE;
                        txDone <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    rx_state_t rxState_r;
    logic [3:0] rxSub_r, rxBit_r;
    logic rxFinish_r;
    logic [DATA_BITS:0] rxShiftVal;

    wire logic [3:0] rxLastAsync = (mode == MODE_UART8) ?
        4'(RX_SAMPLES_8 - 1) : 4'(RX_SAMPLES_9 - 1);
    wire logic rxStartShift = (rxState_r == RX_IDLE) && (mode == MODE_SHIFT) &&
        rxEnable && !rxDoneFlag && (txState_r != TX_SHIFT) && !txLoad;
    wire logic rxStartAsync = (rxState_r == RX_IDLE) && (mode != MODE_SHIFT) &&
        rxEnable && !rxdIn;
    wire logic rxSampleEnd = tick16 && (rxSub_r == 4'(OVERSAMPLE - 1));
    wire logic rxShiftSample = (rxState_r == RX_SHIFT) && (rxSub_r == 4'(SHIFT_DIV - 1));
    // the stop sample of modes 2/3 is not kept
    wire logic rxKeep = (rxState_r == RX_DATA) && rxSampleEnd && (rxBit_r <= 4'(DATA_BITS));
    // mode 0 leaves the byte in the top eight bits, async frames in the low eight
    wire logic rxFrameOk = (mode == MODE_SHIFT) || !mpEnable || rxShiftVal[DATA_BITS];

    assign rxData = (mode == MODE_SHIFT) ? rxShiftVal[DATA_BITS:1] : rxShiftVal[DATA_BITS-1:0];
    assign rxNinth = rxShiftVal[DATA_BITS];
    // a finished byte is dropped while the previous one is unread
    assign rxStore = rxFinish_r && !rxDoneFlag && rxFrameOk;
    assign rxBusy = (rxState_r != RX_IDLE);

    bit_shifter #(.W(DATA_BITS + 1)) u_rxShift (
        .clk(clk),
        .srst(srst),
        .load(1'b0),
        .loadValue('1),
        .shiftEn(rxKeep || rxShiftSample),
        .serialIn(rxdIn),
        .value(rxShiftVal)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            rxState_r <= RX_IDLE;
            rxSub_r <= '0;
            rxBit_r <= '0;
            rxFinish_r <= 1'b0;
        end else begin
            rxFinish_r <= 1'b0;
            unique case (rxState_r)
                RX_IDLE: begin
                    rxSub_r <= '0;
                    rxBit_r <= '0;
                    if (rxStartShift)
                        rxState_r <= RX_SHIFT;
                    else if (rxStartAsync)
                        rxState_r <= RX_START;
                end
                RX_START: begin
                    if (tick16) begin
                        rxSub_r <= rxSub_r + 4'h1;
                        if (rxSub_r == 4'(SAMPLE_POINT - 1)) begin
                            rxSub_r <= '0;
                            rxState_r <= rxdIn ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick16)
                        rxSub_r <= rxSampleEnd ? 4'h0 : rxSub_r + 4'h1;
                    if (rxSampleEnd) begin
                        rxBit_r <= rxBit_r + 4'h1;
                        if (rxBit_r == rxLastAsync) begin
                            rxState_r <= RX_IDLE;
                            rxFinish_r <= 1'b1;
                        end
                    end
                end
                RX_SHIFT: begin
                    rxSub_r <= rxShiftSample ? 4'h0 : rxSub_r + 4'h1;
                    if (rxShiftSample) begin
                        rxBit_r <= rxBit_r + 4'h1;
                        if (rxBit_r == 4'(DATA_BITS - 1)) begin
                            rxState_r <= RX_IDLE;
                            rxFinish_r <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic txd_r, rxdOut_r, rxdOe_r;

    // shift clock is low for the first half of each bit, data settles then
    wire logic txShiftClk = (txSub_r >= 4'(SHIFT_HALF));
    wire logic rxShiftClk = (rxSub_r >= 4'(SHIFT_HALF));
    wire logic txdNext = (txState_r == TX_SHIFT) ? txShiftClk :
        (rxState_r == RX_SHIFT) ? rxShiftClk :
        (txState_r == TX_ASYNC) ? txFrame[0] : 1'b1;

    assign txd = txd_r;
    assign rxdOut = rxdOut_r;
    assign rxdOe = rxdOe_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            txd_r <= 1'b1;
            rxdOut_r <= 1'b1;
            rxdOe_r <= 1'b0;
        end else begin
            txd_r <= txdNext;
            rxdOut_r <= txFrame[0];
            rxdOe_r <= (txState_r == TX_SHIFT);
        end
    end
endmodule

// [test/serial_port_checker.sv]
`timescale 1ns/1ps
module serial_port_checker (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // serial pins
    input wire logic rxdOut,
    input wire logic rxdOe,
    input wire logic txd
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    property p_bhold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response not held");
    property p_rhold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_wresp;
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
    endproperty
    a_wresp: assert property (p_wresp) else $error("write response missing");
    property p_rresp;
        arvalid && arready |=> rvalid;
    endproperty
    a_rresp: assert property (p_rresp) else $error("read data late");
    property p_arlow;
        arvalid && arready |=> !arready;
    endproperty
    a_arlow: assert property (p_arlow) else $error("second read accepted");
    property p_busy;
        bvalid |-> !awready && !wready;
    endproperty
    a_busy: assert property (p_busy) else $error("write accepted while answering");

    // ------------------------------------------------------------
    // shift mode pins
    // ------------------------------------------------------------
    property p_clklow;
        rxdOe && $fell(txd) |-> (!txd) [*6] ##1 txd;
    endproperty
    a_clklow: assert property (p_clklow) else $error("shift clock phase wrong");
    property p_datahold;
        rxdOe && txd && $past(txd) |-> $stable(rxdOut);
    endproperty
    a_datahold: assert property (p_datahold) else $error("shift data moved in high phase");

    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_shift: cover property (rxdOe && $rose(txd));
endmodule

// [test/remote_serial_node.sv]
`timescale 1ns/1ps
module remote_serial_node (
    // clock
    input wire logic clk,
    // serial lines
    input wire logic txd,
    output logic line
);
    initial line = 1'b1;

    // drive a frame bit 0 first, then back to the idle high level
    task automatic sendBits(input logic [10:0] bits, input int n, input int bitClk);
        for (int i = 0; i < n; i++) begin
            line <= bits[i];
            repeat (bitClk) @(posedge clk);
        end
        line <= 1'b1;
    endtask

    // sample each bit of a txd frame in its middle; all ones on timeout
    task automatic recvBits(input int bitClk, input int n, output logic [10:0] bits);
        int t;
        bits = '1;
        for (t = 0; t < 3000 && txd !== 1'b0; t++) @(posedge clk);
        if (t < 3000) begin
            repeat (bitClk / 2) @(posedge clk);
            for (int i = 0; i < n; i++) begin
                bits[i] = txd;
                repeat (bitClk) @(posedge clk);
            end
        end
    endtask
endmodule

// [test/test_four_mode_serial_port.sv]
`timescale 1ns/1ps
module test_four_mode_serial_port;
    import serial_port_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [ADDR_W-1:0] araddr = '0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic t1Overflow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rxdOut, rxdOe, txd, remoteLine, rxdIn;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int failures = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;
    // overflow pulse every second cycle
    always @(posedge clk) t1Overflow <= ~t1Overflow;
    assign rxdIn = rxdOe ? rxdOut : remoteLine;

    four_mode_serial_port u_four_mode_serial_port (.clk(clk), .srst(srst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe),
        .txd(txd), .t1Overflow(t1Overflow));
    remote_serial_node u_remote_serial_node (.clk(clk), .txd(txd), .line(remoteLine));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic giveUp();
        failures++;
        $display("unexpected at %0t: wait timed out", $time);
        summarize();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 100) giveUp();
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n == 100) giveUp();
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [7:0] e, input string what);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, {24'h00_0000, e}, what);
    endtask
    task automatic waitTxd(input logic lvl);
        int n;
        for (n = 0; n < 200 && txd !== lvl; n++) @(posedge clk);
        if (n == 200) giveUp();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testReset();
        logic [31:0] d;
        logic [1:0] r;
        rdChk(OFS_CONTROL, CTRL_RESET, "control reset");
        rdChk(OFS_POWER, 8'h00, "power reset");
        rd(4'h2, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    endtask
    task automatic testTransmit9();
        logic [10:0] bits;
        wr(OFS_POWER, 8'h80);
        wr(OFS_CONTROL, 8'h88);
        wr(OFS_BUFFER, 8'hA5);
        u_remote_serial_node.recvBits(32, 11, bits);
        chk({21'h0, bits}, {21'h0, 2'b11, 8'hA5, 1'b0}, "mode 2 frame");
        rdChk(OFS_CONTROL, 8'h8A, "transmit done");
        rdChk(OFS_CONTROL, 8'h8A, "transmit done held");
        wr(OFS_CONTROL, 8'h80);
        rdChk(OFS_CONTROL, 8'h80, "transmit done cleared");
    endtask
    task automatic testMulti();
        wr(OFS_CONTROL, 8'hF0);
        u_remote_serial_node.sendBits({2'b10, 8'h3C, 1'b0}, 11, 32);
        rdChk(OFS_CONTROL, 8'hF0, "data byte filtered");
        // stop bit low, ignored in the nine bit modes
        u_remote_serial_node.sendBits({2'b01, 8'h5A, 1'b0}, 11, 32);
        rdChk(OFS_CONTROL, 8'hF5, "address byte kept");
        u_remote_serial_node.sendBits({2'b11, 8'h77, 1'b0}, 11, 32);
        rdChk(OFS_BUFFER, 8'h5A, "unread byte kept");
    endtask
    task automatic testMode1();
        logic [10:0] bits;
        wr(OFS_CONTROL, 8'h40);
        u_remote_serial_node.sendBits({2'b11, 8'h81, 1'b0}, 10, 32);
        rdChk(OFS_CONTROL, 8'h40, "receive disabled");
        wr(OFS_CONTROL, 8'h50);
        fork
            wr(OFS_BUFFER, 8'h3E);
            u_remote_serial_node.sendBits({2'b11, 8'hC3, 1'b0}, 10, 32);
            u_remote_serial_node.recvBits(32, 10, bits);
        join
        chk({21'h0, bits}, {21'h0, 2'b11, 8'h3E, 1'b0}, "mode 1 frame");
        rdChk(OFS_CONTROL, 8'h57, "mode 1 receive");
        rdChk(OFS_BUFFER, 8'hC3, "mode 1 data");
    endtask
    task automatic testMode0();
        logic [7:0] got;
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_BUFFER, 8'h96);
        for (int i = 0; i < 8; i++) begin
            waitTxd(1'b0);
            waitTxd(1'b1);
            got[i] = rxdOut;
        end
        chk({24'h00_0000, got}, 32'h0000_0096, "mode 0 data out");
        repeat (12) @(posedge clk);
        rdChk(OFS_CONTROL, 8'h02, "mode 0 transmit done");
        wr(OFS_CONTROL, 8'h10);
        // receive starts at this edge; line changes half a bit before each sample
        repeat (6) @(posedge clk);
        u_remote_serial_node.sendBits({3'b000, 8'h69}, 8, 12);
        rdChk(OFS_CONTROL, 8'h11, "mode 0 receive");
        rdChk(OFS_BUFFER, 8'h69, "mode 0 data in");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        testReset();
        testTransmit9();
        testMulti();
        testMode1();
        testMode0();
        summarize();
    end
endmodule

bind four_mode_serial_port serial_port_checker u_serial_port_checker (.clk(clk), .srst(srst),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready), .rxdOut(rxdOut), .rxdOe(rxdOe), .txd(txd));
